// >>> ccm_top.sv
/*
 * Calibration command interpreter: command window, command mode, word store,
 * response byte with result and diagnostics, ready output.
 * Assumes diagnostic inputs are pulses from logic on clk_in and that the
 * link engine runs on link_clk_in, unrelated to clk_in.
 */
`timescale 1ns/1ps
module ccm_top
  import ccm_pkg::*;
#(
  parameter int         READ_CYCLES   = READ_CYC,
  parameter int         WRITE_CYCLES  = WRITE_CYC,
  parameter int         WINDOW_CYCLES = WINDOW_CYC,
  parameter logic [7:0] REVISION      = REV_DEF
)
(
  // clocks and reset
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic       link_clk_in,
  // link write side
  input  wire logic       lk_start_in,
  input  wire logic       lk_wr_valid_in,
  input  wire logic [7:0] lk_wr_byte_in,
  input  wire logic       lk_stop_in,
  // link fetch side
  input  wire logic       lk_rd_start_in,
  input  wire logic       lk_rd_next_in,
  output logic      [7:0] lk_rd_byte_out,
  // status and diagnostics
  input  wire logic       mem_locked_in,
  input  wire logic       ecc_corrected_in,
  input  wire logic       ecc_uncorrectable_in,
  input  wire logic       ram_parity_in,
  input  wire logic       cfg_parity_in,
  // mode and handshake outputs
  output logic            ready_out,
  output logic            cmd_mode_out,
  output logic            normal_mode_out
);
  ccm_xfer_if xfer ();

  ccm_link u_link (
    .link_clk_in    (link_clk_in),
    .srst_in        (srst_in),
    .lk_start_in    (lk_start_in),
    .lk_wr_valid_in (lk_wr_valid_in),
    .lk_wr_byte_in  (lk_wr_byte_in),
    .lk_stop_in     (lk_stop_in),
    .lk_rd_start_in (lk_rd_start_in),
    .lk_rd_next_in  (lk_rd_next_in),
    .lk_rd_byte_out (lk_rd_byte_out),
    .xfer           (xfer)
  );

  ccm_state_type      state_reg;
  ccm_op_type         op_reg;
  ccm_op_type         op_next;
  logic [31:0]        timer_reg;
  logic [31:0]        len_next;
  logic [ADDR_W-1:0]  addr_reg;
  logic [WORD_W-1:0]  data_reg;
  logic [WORD_W-1:0]  mem_reg [MEM_WORDS];
  logic               cmd_s1_reg;
  logic               cmd_s2_reg;
  logic               cmd_seen_reg;
  logic               new_cmd;
  logic               accept;
  logic               finish;
  logic [7:0]         cmd_byte;
  logic [15:0]        cmd_data;
  logic [ADDR_W-1:0]  cmd_addr;
  logic               is_read;
  logic               is_write;
  logic               locked_hit;
  logic [3:0]         diag_reg;
  logic [3:0]         diag_in;
  logic [23:0]        resp_reg;
  logic               resp_tgl_reg;
  logic [23:0]        pub_word_reg;
  logic [2:0]         gap_reg;

  // command toggle crossing from the link domain
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cmd_s1_reg   <= 1'b0;
      cmd_s2_reg   <= 1'b0;
      cmd_seen_reg <= 1'b0;
    end else begin
      cmd_s1_reg   <= xfer.cmd_tgl;
      cmd_s2_reg   <= cmd_s1_reg;
      cmd_seen_reg <= cmd_s2_reg;
    end
  end

  // commands come only from the link packet path
  assign new_cmd  = cmd_s2_reg ^ cmd_seen_reg;
  assign cmd_byte = xfer.cmd_word[23:16];
  assign cmd_data = xfer.cmd_word[15:0];
  assign cmd_addr = cmd_byte[ADDR_W-1:0];
  assign is_read  = cmd_byte[7:5] == CMD_RD_GROUP;
  assign is_write = cmd_byte[7:5] == CMD_WR_GROUP;
  assign accept   = new_cmd && (state_reg == st_idle);
  assign finish   = (state_reg == st_busy) && (timer_reg == 32'h1);
  assign diag_in  = {cfg_parity_in, ram_parity_in,
                     ecc_uncorrectable_in, ecc_corrected_in};
  assign locked_hit = is_write && (cmd_addr < LOCK_LIMIT) &&
                      mem_locked_in;

  // decode of an accepted command
  always_comb begin
    op_next  = op_nack;
    len_next = 32'h1;
    if (is_read) begin
      op_next  = op_read;
      len_next = 32'(READ_CYCLES);
    end else if (is_write && !locked_hit) begin
      op_next  = op_write;
      len_next = 32'(WRITE_CYCLES);
    end else if (cmd_byte == CMD_REV) begin
      op_next  = op_rev;
      len_next = 32'(READ_CYCLES);
    end
  end

  // mode sequencing
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_reg <= st_window;
      op_reg    <= op_nack;
      timer_reg <= 32'(WINDOW_CYCLES);
      addr_reg  <= '0;
      data_reg  <= WORD_RST;
    end else begin
      unique case (state_reg)
        st_window: begin
          if (new_cmd && cmd_byte == CMD_ENTER && cmd_data == 16'h0000) begin
            state_reg <= st_busy;
            op_reg    <= op_enter;
            timer_reg <= 32'(READ_CYCLES);
          end else if (timer_reg <= 32'h1) begin
            state_reg <= st_normal;
          end else begin
            timer_reg <= timer_reg - 32'h1;
          end
        end
        st_idle: begin
          if (accept && cmd_byte == CMD_LEAVE) begin
            state_reg <= st_normal;
          end else if (accept) begin
            state_reg <= st_busy;
            op_reg    <= op_next;
            timer_reg <= len_next;
            addr_reg  <= cmd_addr;
            data_reg  <= cmd_data;
          end
        end
        st_busy: begin
          if (finish) begin
            state_reg <= st_idle;
          end else begin
            timer_reg <= timer_reg - 32'h1;
          end
        end
        st_normal: begin
          state_reg <= st_normal;
        end
      endcase
    end
  end

  // mode outputs
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cmd_mode_out    <= 1'b0;
      normal_mode_out <= 1'b0;
    end else begin
      cmd_mode_out    <= (state_reg == st_idle || state_reg == st_busy) &&
                         !(accept && cmd_byte == CMD_LEAVE);
      normal_mode_out <= (state_reg == st_normal) ||
                         (accept && cmd_byte == CMD_LEAVE);
    end
  end

  // word store
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem_reg[i] <= WORD_RST;
      end
    end else if (finish && op_reg == op_write) begin
      mem_reg[addr_reg] <= data_reg;
    end
  end

  // diagnostics; a new event beats the clear at accept
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      diag_reg <= 4'h0;
    end else if (accept) begin
      diag_reg <= {diag_reg[DIAG_CFG], 3'h0} | diag_in;
    end else begin
      diag_reg <= diag_reg | diag_in;
    end
  end

  // response word and ready
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      resp_reg     <= {MODE_MARK, 4'h0, RES_BUSY, FILL_BYTE, FILL_BYTE};
      ready_out    <= 1'b0;
    end else if ((state_reg == st_window && new_cmd && cmd_byte == CMD_ENTER
                  && cmd_data == 16'h0000) ||
                 (accept && cmd_byte != CMD_LEAVE)) begin
      resp_reg     <= {MODE_MARK, diag_reg, RES_BUSY, FILL_BYTE, FILL_BYTE};
      ready_out    <= 1'b0;
    end else if (finish) begin
      ready_out    <= 1'b1;
      unique case (op_reg)
        op_read:  resp_reg <= {MODE_MARK, diag_reg | diag_in, RES_ACK,
                               mem_reg[addr_reg]};
        op_rev:   resp_reg <= {MODE_MARK, diag_reg | diag_in, RES_ACK,
                               REVISION, FILL_BYTE};
        op_nack:  resp_reg <= {MODE_MARK, diag_reg | diag_in, RES_NACK,
                               FILL_BYTE, FILL_BYTE};
        default:  resp_reg <= {MODE_MARK, diag_reg | diag_in, RES_ACK,
                               FILL_BYTE, FILL_BYTE};
      endcase
    end else if (state_reg == st_idle && (diag_reg | diag_in) != diag_reg)
    begin
      resp_reg[21:18] <= diag_reg | diag_in;
    end
  end

  // publish to the link; each word holds for at least 8 clk_in cycles (PUB_GAP + 1), with no capture handshake
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pub_word_reg <= {MODE_MARK, 4'h0, RES_BUSY, FILL_BYTE, FILL_BYTE};
      resp_tgl_reg <= 1'b0;
      gap_reg      <= 3'h0;
    end else if (gap_reg != 3'h0) begin
      gap_reg <= gap_reg - 3'h1;
    end else if (pub_word_reg != resp_reg) begin
      pub_word_reg <= resp_reg;
      resp_tgl_reg <= ~resp_tgl_reg;
      gap_reg      <= 3'(PUB_GAP);
    end
  end

  assign xfer.resp_word = pub_word_reg;
  assign xfer.resp_tgl  = resp_tgl_reg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  chk_mode_marker: assert property (
    resp_reg[23:22] == MODE_MARK)
    else $error("response lost its mode marker");
  chk_busy_code: assert property (
    (state_reg == st_busy) |-> resp_reg[17:16] == RES_BUSY)
    else $error("result not busy while executing");
  chk_ready_low: assert property (
    (state_reg == st_busy) |-> !ready_out)
    else $error("ready high during execution");
  chk_ready_rise: assert property (
    finish |=> ready_out && state_reg == st_idle && resp_reg[17:16] != RES_BUSY)
    else $error("ready did not rise on completion");
  chk_read_data: assert property (
    (finish && op_reg == op_read) |=>
      resp_reg[15:0] == $past(mem_reg[addr_reg]) && resp_reg[17:16] == RES_ACK)
    else $error("read data not returned");
  chk_read_time: assert property (
    (accept && is_read) |=> timer_reg == 32'(READ_CYCLES) ##1
      (state_reg == st_busy && !ready_out)[*3])
    else $error("read timing wrong");
  chk_lock_nack: assert property (
    (accept && locked_hit) |=> op_reg == op_nack ##1
      resp_reg[17:16] == RES_NACK && ready_out)
    else $error("locked write not refused");
  chk_leave_mode: assert property (
    (accept && cmd_byte == CMD_LEAVE) |=> normal_mode_out && !cmd_mode_out
      && state_reg == st_normal)
    else $error("leave command did not end command mode");
  chk_normal_stays: assert property (
    (state_reg == st_normal) |=>
      state_reg == st_normal && ready_out == $past(ready_out))
    else $error("command accepted outside the window");
  chk_rev_byte: assert property (
    (finish && op_reg == op_rev) |=> resp_reg[15:8] == REVISION)
    else $error("revision byte wrong");
  chk_diag_corr: assert property (
    (state_reg == st_busy && ecc_corrected_in && !finish) |=> diag_reg[DIAG_CORR])
    else $error("corrected error flag lost");

  cov_enter: cover property (state_reg == st_window ##1 state_reg == st_busy);
  cov_read:  cover property (finish && op_reg == op_read);
  cov_write: cover property (finish && op_reg == op_write);
  cov_leave: cover property (accept && cmd_byte == CMD_LEAVE);
endmodule // ccm_top

// >>> ccm_pkg.sv
/*
 * Constants, timing counts, command encodings and state types for the
 * calibration command interpreter.
 * Assumes a 125 MHz core clock; all derived counts follow from it.
 */
// Functional notes
// - Enter command mode only on code A0 with zero data inside power-on window.
// - Commands arrive only over the I2C link, never over SPI or pulse outputs.
// - Codes 00 to 1F read a stored word in about 100 us.
// - Codes 40 to 5F write the data field to a word in about 12 ms.
// - Code 80 leaves command mode and starts normal operation.
// - Code B0 fetches part revision in about 100 us, returned after response.
// - Revision byte holds layer letter in upper nibble, metal number lower.
// - Fetch returns response byte first; its top two bits read 10; until the first response is published after reset the link returns 00 bytes.
// - Result code: 00 busy, 01 success, 10 unknown or locked write.
// - Response bit 2 flags a corrected memory error during last command.
// - Bits 3,4,5 flag uncorrectable error, RAM parity, start-up parity.
// - Diagnostic bits are independent of the result code.
// - After a memory read two data bytes follow the response byte.
// - Ready output rises when a command has finished.
// - Store holds thirty-two sixteen-bit words.
// - Words below 16 hex need unlocked memory; 16 to 1F always writable.
package ccm_pkg;
  localparam int CLK_PERIOD_NS  = 8;
  localparam int READ_TIME_US   = 100;
  localparam int WRITE_TIME_MS  = 12;
  localparam int WINDOW_TIME_US = 100;
  localparam int READ_CYC   = (READ_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
  localparam int WRITE_CYC  = (WRITE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
  localparam int WINDOW_CYC = (WINDOW_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;

  localparam int MEM_WORDS = 32;
  localparam int WORD_W    = 16;
  localparam int ADDR_W    = 5;
  localparam int PKT_BYTES = 3;
  localparam int XFER_W    = 24;
  localparam int PUB_GAP   = 7;

  localparam logic [2:0] CMD_RD_GROUP = 3'h0;
  localparam logic [2:0] CMD_WR_GROUP = 3'h2;
  localparam logic [7:0] CMD_LEAVE    = 8'h80;
  localparam logic [7:0] CMD_ENTER    = 8'hA0;
  localparam logic [7:0] CMD_REV      = 8'hB0;
  localparam logic [4:0] LOCK_LIMIT   = 5'h16;

  localparam logic [1:0] MODE_MARK = 2'h2;
  localparam logic [1:0] RES_BUSY  = 2'h0;
  localparam logic [1:0] RES_ACK   = 2'h1;
  localparam logic [1:0] RES_NACK  = 2'h2;
  localparam int DIAG_CORR   = 0;
  localparam int DIAG_UNCORR = 1;
  localparam int DIAG_RAM    = 2;
  localparam int DIAG_CFG    = 3;
  localparam logic [7:0]  FILL_BYTE = 8'hFF;
  localparam logic [15:0] WORD_RST  = 16'h0000;
  localparam logic [7:0]  REV_DEF   = 8'h11;

  typedef enum {st_window, st_idle, st_busy, st_normal} ccm_state_type;
  typedef enum {op_read, op_write, op_rev, op_enter, op_nack} ccm_op_type;
endpackage

// >>> ccm_xfer_if.sv
/*
 * Carrier between the link-clock front end and the core interpreter.
 * Words are held stable while their toggle crosses domains.
 */
`timescale 1ns/1ps
interface ccm_xfer_if;
  logic [23:0] cmd_word;
  logic        cmd_tgl;
  logic [23:0] resp_word;
  logic        resp_tgl;
  modport core (input cmd_word, cmd_tgl, output resp_word, resp_tgl);
  modport link (output cmd_word, cmd_tgl, input resp_word, resp_tgl);
endinterface

// >>> ccm_link.sv
/*
 * Link-clock front end: assembles command packets and serves fetch bytes.
 * Assumes an I2C byte engine on link_clk_in that strips the address byte
 * and gives start, byte and stop strobes as one-cycle pulses.
 */
`timescale 1ns/1ps
module ccm_link
  import ccm_pkg::*;
(
  // clocks and reset
  input  wire logic       link_clk_in,
  input  wire logic       srst_in,
  // write side of the link
  input  wire logic       lk_start_in,
  input  wire logic       lk_wr_valid_in,
  input  wire logic [7:0] lk_wr_byte_in,
  input  wire logic       lk_stop_in,
  // fetch side of the link
  input  wire logic       lk_rd_start_in,
  input  wire logic       lk_rd_next_in,
  output logic      [7:0] lk_rd_byte_out,
  // crossing to core
  ccm_xfer_if.link        xfer
);
  logic        rst_s1_reg;
  logic        rst_reg;
  logic [2:0]  cnt_reg;
  logic [23:0] buf_reg;
  logic [23:0] cmd_reg;
  logic        cmd_tgl_reg;
  logic        resp_s1_reg;
  logic        resp_s2_reg;
  logic        resp_seen_reg;
  logic [23:0] snap_reg;
  logic [1:0]  idx_reg;

  always_ff @(posedge link_clk_in) begin
    rst_s1_reg <= srst_in;
    rst_reg    <= rst_s1_reg;
  end

  // packet assembly; short or long packets are dropped
  always_ff @(posedge link_clk_in) begin
    if (rst_reg) begin
      cnt_reg     <= 3'h0;
      buf_reg     <= 24'h000000;
      cmd_reg     <= 24'h000000;
      cmd_tgl_reg <= 1'b0;
    end else if (lk_start_in) begin
      cnt_reg <= 3'h0;
    end else if (lk_wr_valid_in) begin
      buf_reg <= {buf_reg[15:0], lk_wr_byte_in};
      if (cnt_reg <= 3'(PKT_BYTES)) begin
        cnt_reg <= cnt_reg + 3'h1;
      end
    end else if (lk_stop_in) begin
      if (cnt_reg == 3'(PKT_BYTES)) begin
        cmd_reg     <= buf_reg;
        cmd_tgl_reg <= ~cmd_tgl_reg;
      end
      cnt_reg <= 3'h0;
    end
  end

  assign xfer.cmd_word = cmd_reg;
  assign xfer.cmd_tgl  = cmd_tgl_reg;

  always_ff @(posedge link_clk_in) begin
    if (rst_reg) begin
      resp_s1_reg   <= 1'b0;
      resp_s2_reg   <= 1'b0;
      resp_seen_reg <= 1'b0;
      snap_reg      <= 24'h000000;
    end else begin
      resp_s1_reg   <= xfer.resp_tgl;
      resp_s2_reg   <= resp_s1_reg;
      resp_seen_reg <= resp_s2_reg;
      if (resp_s2_reg != resp_seen_reg) begin
        snap_reg <= xfer.resp_word;
      end
    end
  end

  // response byte, then data msb first, then fill
  always_ff @(posedge link_clk_in) begin
    if (rst_reg) begin
      idx_reg        <= 2'h0;
      lk_rd_byte_out <= FILL_BYTE;
    end else if (lk_rd_start_in) begin
      idx_reg <= 2'h0;
    end else if (lk_rd_next_in) begin
      unique case (idx_reg)
        2'h0: lk_rd_byte_out <= snap_reg[23:16];
        2'h1: lk_rd_byte_out <= snap_reg[15:8];
        2'h2: lk_rd_byte_out <= snap_reg[7:0];
        2'h3: lk_rd_byte_out <= FILL_BYTE;
      endcase
      if (idx_reg != 2'h3) begin
        idx_reg <= idx_reg + 2'h1;
      end
    end
  end
endmodule // ccm_link

// >>> ccm_host_model.sv
/*
 * Host model on the far side of the link: sends command packets and
 * data fetches as byte-engine strobes.
 * Assumes link_clk_in is the design's link clock.
 */
`timescale 1ns/1ps
module ccm_host_model (
  // link clock
  input  wire logic       link_clk_in,
  // strobes toward the design
  output logic            start_out,
  output logic            wr_valid_out,
  output logic      [7:0] wr_byte_out,
  output logic            stop_out,
  output logic            rd_start_out,
  output logic            rd_next_out,
  // fetch data from the design
  input  wire logic [7:0] rd_byte_in
);
  initial begin
    start_out    = 1'b0;
    wr_valid_out = 1'b0;
    wr_byte_out  = 8'h00;
    stop_out     = 1'b0;
    rd_start_out = 1'b0;
    rd_next_out  = 1'b0;
  end

  task automatic send(input logic [7:0] cmd, input logic [15:0] data);
    logic [7:0] pkt [3];
    pkt = '{cmd, data[15:8], data[7:0]};
    @(posedge link_clk_in) start_out <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge link_clk_in) start_out <= 1'b0;
      wr_valid_out <= 1'b1;
      wr_byte_out  <= pkt[i];
    end
    @(posedge link_clk_in) wr_valid_out <= 1'b0;
    // released byte lines show no stale value
    wr_byte_out <= ~pkt[2];
    stop_out    <= 1'b1;
    @(posedge link_clk_in) stop_out <= 1'b0;
  endtask

  task automatic fetch(input int n, output logic [7:0] got [3]);
    got = '{8'h00, 8'h00, 8'h00};
    @(posedge link_clk_in) rd_start_out <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge link_clk_in) rd_start_out <= 1'b0;
      rd_next_out <= 1'b1;
      @(posedge link_clk_in) rd_next_out <= 1'b0;
      @(negedge link_clk_in) got[i] = rd_byte_in;
    end
  endtask
endmodule // ccm_host_model

// >>> tb_ccm_top.sv
/*
 * Self-checking bench for the calibration command interpreter.
 * Assumes shortened execution and window counts set below.
 */
`timescale 1ns/1ps
module tb_ccm_top
  import ccm_pkg::*;
;
  localparam logic [7:0] TB_REV = 8'hC3; // arbitrary revision value

  typedef struct {
    logic [7:0]  cmd;
    logic [15:0] data;
    logic        lock;
    logic [3:0]  pulse;
    int          n;
    logic [3:0]  dexp;
    logic [1:0]  res;
    logic [15:0] word;
  } ccm_row_type;

  logic       clk_in;
  logic       link_clk_in;
  logic       srst_in;
  logic       lk_start;
  logic       lk_wr_valid;
  logic [7:0] lk_wr_byte;
  logic       lk_stop;
  logic       lk_rd_start;
  logic       lk_rd_next;
  logic [7:0] lk_rd_byte;
  logic       mem_locked_in;
  logic [3:0] diag;
  logic       ready_out;
  logic       cmd_mode_out;
  logic       normal_mode_out;
  logic [7:0] got [3];
  int         n_errors = 0;
  int         num_checks = 0;

  // (row 60 is the only unlisted code, expected refused)
  ccm_row_type rows [11] = '{
    '{8'h56, 16'h1234, 1'b1, 4'h0, 1, 4'h0, RES_ACK,  16'h0000},
    '{8'h16, 16'h0000, 1'b1, 4'h0, 3, 4'h0, RES_ACK,  16'h1234},
    '{8'h55, 16'hBEEF, 1'b1, 4'h0, 1, 4'h0, RES_NACK, 16'h0000},
    '{8'h15, 16'h0000, 1'b1, 4'h0, 3, 4'h0, RES_ACK,  16'h0000},
    '{8'h40, 16'hABCD, 1'b0, 4'h0, 1, 4'h0, RES_ACK,  16'h0000},
    '{8'h00, 16'h0000, 1'b0, 4'h1, 3, 4'h1, RES_ACK,  16'hABCD},
    '{8'h40, 16'hABCD, 1'b0, 4'h0, 1, 4'h0, RES_ACK,  16'h0000},
    '{8'h5F, 16'h5A5A, 1'b0, 4'h6, 1, 4'h6, RES_ACK,  16'h0000},
    '{8'h1F, 16'h0000, 1'b0, 4'h0, 3, 4'h0, RES_ACK,  16'h5A5A},
    '{8'hB0, 16'h0000, 1'b0, 4'h0, 2, 4'h0, RES_ACK,  {TB_REV, 8'h00}},
    '{8'h60, 16'h0000, 1'b0, 4'h0, 1, 4'h0, RES_NACK, 16'h0000}
  };

  ccm_top #(
    .READ_CYCLES   (20),
    .WRITE_CYCLES  (40),
    .WINDOW_CYCLES (200),
    .REVISION      (TB_REV)
  ) i_ccm_top (
    .clk_in               (clk_in),
    .srst_in              (srst_in),
    .link_clk_in          (link_clk_in),
    .lk_start_in          (lk_start),
    .lk_wr_valid_in       (lk_wr_valid),
    .lk_wr_byte_in        (lk_wr_byte),
    .lk_stop_in           (lk_stop),
    .lk_rd_start_in       (lk_rd_start),
    .lk_rd_next_in        (lk_rd_next),
    .lk_rd_byte_out       (lk_rd_byte),
    .mem_locked_in        (mem_locked_in),
    .ecc_corrected_in     (diag[0]),
    .ecc_uncorrectable_in (diag[1]),
    .ram_parity_in        (diag[2]),
    .cfg_parity_in        (diag[3]),
    .ready_out            (ready_out),
    .cmd_mode_out         (cmd_mode_out),
    .normal_mode_out      (normal_mode_out)
  );

  ccm_host_model i_ccm_host_model (
    .link_clk_in  (link_clk_in),
    .start_out    (lk_start),
    .wr_valid_out (lk_wr_valid),
    .wr_byte_out  (lk_wr_byte),
    .stop_out     (lk_stop),
    .rd_start_out (lk_rd_start),
    .rd_next_out  (lk_rd_next),
    .rd_byte_in   (lk_rd_byte)
  );

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  initial begin
    link_clk_in = 1'b0;
    #3;
    forever #6 link_clk_in = ~link_clk_in;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // sel 0 watches ready_out, sel 1 watches normal_mode_out
  task automatic wait_lvl(input int sel, input logic lvl, input int lim);
    int k;
    k = 0;
    while (((sel == 1) ? normal_mode_out : ready_out) !== lvl && k < lim)
    begin
      @(posedge clk_in);
      k++;
    end
    if (k >= lim) begin
      n_errors++;
      $display("CHECK FAILED wait on status output timed out");
      tally_and_finish;
    end
  endtask

  task automatic fetch_check(input int n, input logic [7:0] exp);
    repeat (16) @(posedge clk_in);
    i_ccm_host_model.fetch(n, got);
    check("response", got[0], exp);
  endtask

  task automatic run_row(input ccm_row_type r);
    @(posedge clk_in) mem_locked_in <= r.lock;
    i_ccm_host_model.send(r.cmd, r.data);
    wait_lvl(0, 1'b0, 40);
    @(posedge clk_in) diag <= r.pulse;
    @(posedge clk_in) diag <= 4'h0;
    wait_lvl(0, 1'b1, 50000);
    fetch_check(r.n, {MODE_MARK, r.dexp, r.res});
    if (r.n > 1) check("data msb", got[1], r.word[15:8]);
    if (r.n > 2) check("data lsb", got[2], r.word[7:0]);
    $display("test row cmd %h done", r.cmd);
  endtask

  initial begin
    srst_in       = 1'b1;
    mem_locked_in = 1'b0;
    diag          = 4'h0;
    repeat (6) @(posedge clk_in);
    check("reset ready", {7'h0, ready_out}, 8'h00);
    check("reset cmd mode", {7'h0, cmd_mode_out}, 8'h00);
    check("reset normal", {7'h0, normal_mode_out}, 8'h00);
    check("reset fetch byte", lk_rd_byte, FILL_BYTE);
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    $display("test reset done");
    // a read inside the window does not open command mode
    i_ccm_host_model.send(8'h16, 16'h0000);
    repeat (20) @(posedge clk_in);
    check("window other code", {7'h0, cmd_mode_out}, 8'h00);
    i_ccm_host_model.send(CMD_ENTER, 16'h0000);
    wait_lvl(0, 1'b1, 1000);
    check("enter", {7'h0, cmd_mode_out}, 8'h01);
    fetch_check(1, {MODE_MARK, 4'h0, RES_ACK});
    $display("test enter done");
    foreach (rows[i]) run_row(rows[i]);
    // start-up parity flag in idle is republished and stays
    @(posedge clk_in) diag <= 4'h8;
    @(posedge clk_in) diag <= 4'h0;
    fetch_check(1, {MODE_MARK, 4'h8, RES_NACK});
    $display("test idle diag done");
    i_ccm_host_model.send(8'h57, 16'h0F0F);
    wait_lvl(0, 1'b0, 40);
    fetch_check(1, {MODE_MARK, 4'h8, RES_BUSY});
    wait_lvl(0, 1'b1, 50000);
    fetch_check(1, {MODE_MARK, 4'h8, RES_ACK});
    $display("test busy poll done");
    i_ccm_host_model.send(CMD_LEAVE, 16'h0000);
    wait_lvl(1, 1'b1, 60);
    check("leave cmd mode", {7'h0, cmd_mode_out}, 8'h00);
    check("leave ready", {7'h0, ready_out}, 8'h01);
    i_ccm_host_model.send(CMD_ENTER, 16'h0000);
    repeat (40) @(posedge clk_in);
    check("late enter", {7'h0, cmd_mode_out}, 8'h00);
    check("late normal", {7'h0, normal_mode_out}, 8'h01);
    $display("test leave done");
    // second reset: enter with nonzero data is ignored, window lapses
    srst_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    srst_in <= 1'b0;
    check("reset again normal", {7'h0, normal_mode_out}, 8'h00);
    repeat (10) @(posedge clk_in);
    i_ccm_host_model.send(CMD_ENTER, 16'h0001);
    wait_lvl(1, 1'b1, 300);
    check("lapse cmd mode", {7'h0, cmd_mode_out}, 8'h00);
    check("lapse ready", {7'h0, ready_out}, 8'h00);
    $display("test window lapse done");
    tally_and_finish;
  end
endmodule // tb_ccm_top
